// [core/pifr_consts.svh]
// Purpose: Offsets, field positions and reset values of the flag block
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes: Included by the package and by the top module
`ifndef PIFR_CONSTS_SVH
`define PIFR_CONSTS_SVH

// Byte offsets on the register bus
`define PIFR_OFF_REQ3 5'h00
`define PIFR_OFF_REQ4 5'h04
`define PIFR_OFF_ENABLE 5'h08
`define PIFR_OFF_CLEAR 5'h0c
`define PIFR_OFF_CELL_CFG 5'h10
`define PIFR_OFF_CCP_MODE 5'h14

// Bit positions in request register 3
`define PIFR_B3_TIMER3_OVF 4
`define PIFR_REQ3_IMPL_MASK 8'h1f

// Bit positions in request register 4
`define PIFR_B4_WAVEGEN2 7
`define PIFR_B4_WAVEGEN1 6
`define PIFR_B4_TIMER5_GATE 5
`define PIFR_B4_TIMER5_OVF 4
`define PIFR_B4_CAPCOMP3 2
`define PIFR_B4_CAPCOMP2 1
`define PIFR_B4_CAPCOMP1 0

// Reset values
`define PIFR_RST_REQ 8'h00
`define PIFR_RST_ENABLE 16'h0000
`define PIFR_RST_CELL_CFG 8'h0f
`define PIFR_RST_CCP_MODE 8'h00

// Number of synchronised event lines
`define PIFR_NUM_EVENTS 21

`endif

// [core/pifr_pkg.sv]
// Purpose: Types shared by the flag block
// Assumes: Constants come from pifr_consts.svh
// Notes: Holds the mode enum and the state records
package pifr_pkg;
  `include "pifr_consts.svh"

  // Per-unit capture/compare/PWM mode, two bits per unit
  typedef enum logic [1:0] {
    PIFR_MODE_OFF = 2'h0,
    PIFR_MODE_CAPTURE = 2'h1,
    PIFR_MODE_COMPARE = 2'h3,
    PIFR_MODE_PWM = 2'h2
  } pifr_mode_t;

  // Edge detector state
  typedef struct packed {
    logic [`PIFR_NUM_EVENTS-1:0] meta;
    logic [`PIFR_NUM_EVENTS-1:0] sync;
    logic [`PIFR_NUM_EVENTS-1:0] last;
  } pifr_edge_state_t;

  // Register file and bus state
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    logic [7:0] req3;
    logic [7:0] req4;
    logic [15:0] enable;
    logic [7:0] cell_cfg;
    logic [7:0] ccp_mode;
    logic irq;
  } pifr_state_t;
endpackage

// [core/pifr_edge_sync.sv]
// Purpose: Two-stage synchroniser with rise and fall pulses per line
// Assumes: Inputs are asynchronous levels from other logic or pins
// Notes: Pulses last one clock; the first stage feeds only the second
`timescale 1ns/1ps
module pifr_edge_sync #(
  parameter int WIDTH = 21
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  import pifr_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;
  logic [3*WIDTH-1:0] st_reg;
  logic [3*WIDTH-1:0] st_next;

  // Stage order: meta, sync, last
  always_comb begin
    st_next = {level_in, st_reg[3*WIDTH-1:2*WIDTH], st_reg[2*WIDTH-1:WIDTH]};
  end

  // Reset clears every stage so no pulse appears at release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign meta_reg = st_reg[3*WIDTH-1:2*WIDTH];
  assign sync_reg = st_reg[2*WIDTH-1:WIDTH];
  assign last_reg = st_reg[WIDTH-1:0];

  // Edges from the second and third stages only
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule

// [core/pifr_flag_regs.sv]
// Purpose: Peripheral interrupt request flag registers 3 and 4
// Assumes: Event inputs are levels, possibly from another clock domain
// Notes: Avalon-MM slave, one wait state per transfer
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pifr_consts.svh"
module pifr_flag_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer3_overflow,
  input wire logic [3:0] logic_cell_output,
  input wire logic [1:0] wavegen_shutdown,
  input wire logic timer5_gate_event,
  input wire logic timer5_overflow,
  input wire logic [3:0] capcomp_capture,
  input wire logic [3:0] capcomp_match,
  input wire logic [3:0] capcomp_pwm_output,
  output logic irq
);
  import pifr_pkg::*;

  pifr_state_t st_reg;
  pifr_state_t st_next;
  logic [`PIFR_NUM_EVENTS-1:0] ev_level;
  logic [`PIFR_NUM_EVENTS-1:0] ev_rise;
  logic [`PIFR_NUM_EVENTS-1:0] ev_fall;
  logic [7:0] set3;
  logic [7:0] set4;
  logic bus_req;
  logic bus_done;
  logic wr_done;

  // Address match on an aligned word
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr[4:2] == off[4:2]);
  endfunction

  // Set pulse of one capture/compare/PWM unit for its mode
  function automatic logic ccp_set(input pifr_mode_t mode, input logic cap,
                                   input logic mat, input logic pwm_fall);
    case (mode)
      PIFR_MODE_CAPTURE: ccp_set = cap;
      PIFR_MODE_COMPARE: ccp_set = mat;
      PIFR_MODE_PWM: ccp_set = pwm_fall;
      default: ccp_set = 1'b0;
    endcase
  endfunction

  // Event lines: 0 timer3, 4:1 cells, 6:5 gens, 7 gate, 8 t5, then units
  assign ev_level = {capcomp_pwm_output, capcomp_match, capcomp_capture,
                     timer5_overflow, timer5_gate_event, wavegen_shutdown,
                     logic_cell_output, timer3_overflow};

  // Every source is synchronised and reduced to one-clock pulses
  pifr_edge_sync #(
    .WIDTH(`PIFR_NUM_EVENTS)
  ) u_edge (
    .clk(clk),
    .rstn(rstn),
    .level_in(ev_level),
    .rise(ev_rise),
    .fall(ev_fall)
  );

  // A transfer completes on the edge where waitrequest is sampled low
  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~st_reg.waitrequest;
  assign wr_done = avs_write & ~st_reg.waitrequest;

  // Set pulses, gated by cell conditions and unit modes but not by the enable register, so flags record events while masked
  always_comb begin
    set3 = 8'h00;
    set4 = 8'h00;
    set3[`PIFR_B3_TIMER3_OVF] = ev_rise[0];
    for (int i = 0; i < 4; i++) begin
      // Condition per cell: bit i enables rising, bit i+4 enables falling
      set3[i] = (ev_rise[1+i] & st_reg.cell_cfg[i]) |
                (ev_fall[1+i] & st_reg.cell_cfg[4+i]);
    end
    set4[`PIFR_B4_WAVEGEN2] = ev_rise[6];
    set4[`PIFR_B4_WAVEGEN1] = ev_rise[5];
    set4[`PIFR_B4_TIMER5_GATE] = ev_rise[7];
    set4[`PIFR_B4_TIMER5_OVF] = ev_rise[8];
    for (int u = 0; u < 4; u++) begin
      // Bit u holds unit u+1, so unit 3 lands on bit 2
      set4[u] = ccp_set(pifr_mode_t'(st_reg.ccp_mode[2*u +: 2]), ev_rise[9+u],
                        ev_rise[13+u], ev_fall[17+u]);
    end
  end

  // Next state of the bus slave and of every register
  always_comb begin
    st_next = st_reg;
    // One wait state, then waitrequest drops for exactly one edge
    st_next.waitrequest = ~(bus_req & st_reg.waitrequest);
    if (avs_read & st_reg.waitrequest) begin
      st_next.readdata = 32'h0000_0000;
      if (hit(avs_address, `PIFR_OFF_REQ3)) begin
        st_next.readdata[7:0] = st_reg.req3 & `PIFR_REQ3_IMPL_MASK;
      end else if (hit(avs_address, `PIFR_OFF_REQ4)) begin
        st_next.readdata[7:0] = st_reg.req4;
      end else if (hit(avs_address, `PIFR_OFF_ENABLE)) begin
        st_next.readdata[15:0] = st_reg.enable;
      end else if (hit(avs_address, `PIFR_OFF_CELL_CFG)) begin
        st_next.readdata[7:0] = st_reg.cell_cfg;
      end else if (hit(avs_address, `PIFR_OFF_CCP_MODE)) begin
        st_next.readdata[7:0] = st_reg.ccp_mode;
      end
    end
    // Software writes take effect only on the completing edge
    if (wr_done) begin
      if (avs_byteenable[0]) begin
        if (hit(avs_address, `PIFR_OFF_REQ3)) begin
          st_next.req3 = avs_writedata[7:0] & `PIFR_REQ3_IMPL_MASK;
        end
        if (hit(avs_address, `PIFR_OFF_REQ4)) begin
          st_next.req4 = avs_writedata[7:0];
        end
        if (hit(avs_address, `PIFR_OFF_ENABLE)) begin
          st_next.enable[7:0] = avs_writedata[7:0];
        end
        if (hit(avs_address, `PIFR_OFF_CLEAR)) begin
          st_next.req3 = st_reg.req3 & ~avs_writedata[7:0];
        end
        if (hit(avs_address, `PIFR_OFF_CELL_CFG)) begin
          st_next.cell_cfg = avs_writedata[7:0];
        end
        if (hit(avs_address, `PIFR_OFF_CCP_MODE)) begin
          st_next.ccp_mode = avs_writedata[7:0];
        end
      end
      if (avs_byteenable[1]) begin
        if (hit(avs_address, `PIFR_OFF_ENABLE)) begin
          st_next.enable[15:8] = avs_writedata[15:8];
        end
        if (hit(avs_address, `PIFR_OFF_CLEAR)) begin
          st_next.req4 = st_reg.req4 & ~avs_writedata[15:8];
        end
      end
    end
    // Hardware set is applied last so it wins over any write or clear
    st_next.req3 = (st_next.req3 | set3) & `PIFR_REQ3_IMPL_MASK;
    st_next.req4 = st_next.req4 | set4;
    // Level interrupt from enabled flags, registered with the flags
    st_next.irq = |({st_next.req4, st_next.req3} & st_next.enable);
  end

  // Synchronous reset puts every flag at zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg.waitrequest <= 1'b1;
      st_reg.readdata <= 32'h0000_0000;
      st_reg.req3 <= `PIFR_RST_REQ;
      st_reg.req4 <= `PIFR_RST_REQ;
      st_reg.enable <= `PIFR_RST_ENABLE;
      st_reg.cell_cfg <= `PIFR_RST_CELL_CFG;
      st_reg.ccp_mode <= `PIFR_RST_CCP_MODE;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata = st_reg.readdata;
  assign avs_waitrequest = st_reg.waitrequest;
  assign irq = st_reg.irq;

  // Checks on the flag behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Software clear of a timer 3 flag through either path
  logic t3_clr;
  assign t3_clr = wr_done & avs_byteenable[0] &
                  (hit(avs_address, `PIFR_OFF_REQ3) | hit(avs_address, `PIFR_OFF_CLEAR));

  AST_T3_SET: assert property (ev_rise[0] |=> st_reg.req3[`PIFR_B3_TIMER3_OVF])
    else $error("timer 3 overflow did not set its flag");

  AST_T3_STICKY: assert property (
    st_reg.req3[`PIFR_B3_TIMER3_OVF] && !t3_clr |=> st_reg.req3[`PIFR_B3_TIMER3_OVF])
    else $error("timer 3 flag dropped without a software write");

  AST_CELL_RISE: assert property (
    ev_rise[1] && st_reg.cell_cfg[0] |=> st_reg.req3[0])
    else $error("logic cell 1 condition did not set its flag");

  AST_GEN2_BIT7: assert property (
    $rose(wavegen_shutdown[1]) ##2 1 |=> st_reg.req4[`PIFR_B4_WAVEGEN2])
    else $error("generator 2 shutdown not seen at bit 7");

  AST_CAPTURE_BIT2: assert property (
    ev_rise[11] && st_reg.ccp_mode[5:4] == PIFR_MODE_CAPTURE
    |=> st_reg.req4[`PIFR_B4_CAPCOMP3])
    else $error("unit 3 capture did not set bit 2");

  AST_PWM_FALL: assert property (
    ev_fall[17] && st_reg.ccp_mode[1:0] == PIFR_MODE_PWM
    |=> st_reg.req4[`PIFR_B4_CAPCOMP1])
    else $error("unit 1 trailing edge did not set bit 0");

  AST_SET_WINS: assert property (
    set4[`PIFR_B4_CAPCOMP2] && wr_done && hit(avs_address, `PIFR_OFF_REQ4)
    |=> st_reg.req4[`PIFR_B4_CAPCOMP2])
    else $error("clear beat a hardware set");

  AST_RESET_ZERO: assert property (
    @(posedge clk) disable iff (1'b0) !rstn |=> st_reg.req4 == 8'h00 && st_reg.req3 == 8'h00)
    else $error("flags not zero after reset");

  AST_UNIMPL_ZERO: assert property (
    avs_read && !avs_waitrequest && hit(avs_address, `PIFR_OFF_REQ3)
    |-> avs_readdata[31:5] == 27'h0)
    else $error("unimplemented bits read nonzero");

  // Generator 1 sits directly below generator 2
  AST_GEN1_BIT6: assert property (
    ev_rise[5] |=> st_reg.req4[`PIFR_B4_WAVEGEN1])
    else $error("generator 1 shutdown not seen at bit 6");

  // Timer 5 gate events land regardless of any enable
  AST_T5_GATE: assert property (
    ev_rise[7] |=> st_reg.req4[`PIFR_B4_TIMER5_GATE])
    else $error("timer 5 gate event did not set its flag");

  // Compare mode takes the match line, not the capture line
  AST_COMPARE_SET: assert property (
    ev_rise[14] && st_reg.ccp_mode[3:2] == PIFR_MODE_COMPARE
    |=> st_reg.req4[`PIFR_B4_CAPCOMP2])
    else $error("unit 2 compare match did not set bit 1");

  AST_ONE_PULSE: assert property (
    ev_rise[0] |=> !ev_rise[0])
    else $error("set pulse longer than one cycle");

  AST_WAIT_ONE: assert property (
    bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one edge");

  AST_IRQ_LEVEL: assert property (
    irq == |({st_reg.req4, st_reg.req3} & st_reg.enable))
    else $error("irq does not follow enabled flags");

  COV_T3_FLAG: cover property (ev_rise[0] ##1 st_reg.req3[4] ##[1:20] t3_clr);
  COV_PWM_FLAG: cover property (ev_fall[18] && st_reg.ccp_mode[3:2] == PIFR_MODE_PWM);
  COV_SET_CLEAR: cover property (|set4 && wr_done && hit(avs_address, `PIFR_OFF_CLEAR));
  COV_IRQ: cover property ($rose(irq));
endmodule

// [test/peripheral_irq_flag_regs_tb.sv]
// Purpose: Self-checking bench for the peripheral interrupt flag registers
// Assumes: One wait state per bus transfer; flags land about 3 edges after an event
// Notes: Events are driven as clean levels and held 6 cycles so the synchroniser settles
`timescale 1ns/1ps
`include "pifr_consts.svh"
module peripheral_irq_flag_regs_tb;
  import pifr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic timer3_overflow = 1'b0;
  logic [3:0] logic_cell_output = 4'h0;
  logic [1:0] wavegen_shutdown = 2'h0;
  logic timer5_gate_event = 1'b0;
  logic timer5_overflow = 1'b0;
  logic [3:0] capcomp_capture = 4'h0;
  logic [3:0] capcomp_match = 4'h0;
  logic [3:0] capcomp_pwm_output = 4'h0;
  logic irq;
  int n_mismatch = 0;
  int cmp_count = 0;

  // One compare, counted, reported at once on mismatch
  `define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

  // Half period of 2.5 ns gives 200 MHz
  always #2.5 clk = ~clk;

  pifr_flag_regs u_dut (
    .clk(clk),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .timer3_overflow(timer3_overflow),
    .logic_cell_output(logic_cell_output),
    .wavegen_shutdown(wavegen_shutdown),
    .timer5_gate_event(timer5_gate_event),
    .timer5_overflow(timer5_overflow),
    .capcomp_capture(capcomp_capture),
    .capcomp_match(capcomp_match),
    .capcomp_pwm_output(capcomp_pwm_output),
    .irq(irq)
  );

  // Prints the counts and the verdict, then stops
  task automatic close_out;
    $display("counts: compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Holds the request until the edge that sees waitrequest low, then releases
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= ~rd;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      $display("[ERR] bus wait expected 0 seen timeout");
      close_out();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic chk_reg(input string nm, input logic [4:0] a, input logic [31:0] ex);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    `CHK(nm, ex, q)
  endtask

  // Long enough for the synchroniser and the edge detector to finish
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and unmapped space
    chk_reg("req3 reset", `PIFR_OFF_REQ3, 32'h0);
    chk_reg("req4 reset", `PIFR_OFF_REQ4, 32'h0);
    chk_reg("enable reset", `PIFR_OFF_ENABLE, 32'h0);
    chk_reg("cell cfg reset", `PIFR_OFF_CELL_CFG, 32'h0f);
    chk_reg("mode reset", `PIFR_OFF_CCP_MODE, 32'h0);
    wr(5'h18, 32'hff);
    chk_reg("unmapped", 5'h18, 32'h0);
    chk_reg("clear reads", `PIFR_OFF_CLEAR, 32'h0);
    $display("test reset_values done");

    // Timer 3 flag sets with enables off and sticks after the source drops
    timer3_overflow <= 1'b1;
    settle();
    timer3_overflow <= 1'b0;
    settle();
    chk_reg("timer3 flag", `PIFR_OFF_REQ3, 32'h10);
    `CHK("irq masked", 1'b0, irq)
    wr(`PIFR_OFF_ENABLE, 32'h0010);
    settle();
    `CHK("irq enabled", 1'b1, irq)
    wr(`PIFR_OFF_CLEAR, 32'h0010);
    settle();
    chk_reg("timer3 cleared", `PIFR_OFF_REQ3, 32'h0);
    `CHK("irq cleared", 1'b0, irq)
    $display("test timer3 done");

    // Logic cells: rising edge by default, then falling only
    logic_cell_output <= 4'hf;
    settle();
    chk_reg("cells rise", `PIFR_OFF_REQ3, 32'h0f);
    wr(`PIFR_OFF_CLEAR, 32'h000f);
    wr(`PIFR_OFF_CELL_CFG, 32'hf0);
    logic_cell_output <= 4'h5;
    settle();
    chk_reg("cells fall", `PIFR_OFF_REQ3, 32'h0a);
    logic_cell_output <= 4'hf;
    settle();
    chk_reg("cells no rise", `PIFR_OFF_REQ3, 32'h0a);
    wr(`PIFR_OFF_CLEAR, 32'h00ff);
    $display("test cells done");

    // Wave generators and timer 5 land on the documented bits
    wavegen_shutdown <= 2'h2;
    settle();
    chk_reg("wavegen2", `PIFR_OFF_REQ4, 32'h80);
    wavegen_shutdown <= 2'h3;
    timer5_gate_event <= 1'b1;
    timer5_overflow <= 1'b1;
    settle();
    chk_reg("wavegen1 t5", `PIFR_OFF_REQ4, 32'hf0);
    wr(`PIFR_OFF_CLEAR, 32'hf000);
    settle();
    chk_reg("req4 cleared", `PIFR_OFF_REQ4, 32'h0);
    $display("test wavegen done");

    // Capture/compare/PWM: off, capture, compare, PWM per mode
    capcomp_capture <= 4'hf;
    capcomp_match <= 4'hf;
    capcomp_pwm_output <= 4'hf;
    settle();
    capcomp_capture <= 4'h0;
    capcomp_match <= 4'h0;
    capcomp_pwm_output <= 4'h0;
    settle();
    chk_reg("units off", `PIFR_OFF_REQ4, 32'h0);
    wr(`PIFR_OFF_CCP_MODE, 32'h55);
    capcomp_match <= 4'hf;
    capcomp_capture <= 4'h4;
    settle();
    chk_reg("capture unit3", `PIFR_OFF_REQ4, 32'h04);
    capcomp_capture <= 4'h3;
    settle();
    chk_reg("capture unit1 2", `PIFR_OFF_REQ4, 32'h07);
    wr(`PIFR_OFF_CLEAR, 32'h0f00);
    wr(`PIFR_OFF_CCP_MODE, 32'hff);
    capcomp_match <= 4'h0;
    settle();
    capcomp_match <= 4'ha;
    settle();
    chk_reg("compare", `PIFR_OFF_REQ4, 32'h0a);
    wr(`PIFR_OFF_CLEAR, 32'h0f00);
    wr(`PIFR_OFF_CCP_MODE, 32'haa);
    capcomp_pwm_output <= 4'hf;
    settle();
    chk_reg("pwm lead edge", `PIFR_OFF_REQ4, 32'h0);
    capcomp_pwm_output <= 4'h0;
    settle();
    chk_reg("pwm trail edge", `PIFR_OFF_REQ4, 32'h0f);
    wr(`PIFR_OFF_ENABLE, 32'h0400);
    settle();
    `CHK("irq unit3", 1'b1, irq)
    $display("test capcomp done");

    // Software writes store directly and can zero every bit
    wr(`PIFR_OFF_REQ4, 32'ha5);
    chk_reg("req4 write", `PIFR_OFF_REQ4, 32'ha5);
    wr(`PIFR_OFF_REQ3, 32'hff);
    chk_reg("req3 write", `PIFR_OFF_REQ3, 32'h1f);
    wr(`PIFR_OFF_REQ4, 32'h0);
    settle();
    chk_reg("req4 zero", `PIFR_OFF_REQ4, 32'h0);
    `CHK("irq off", 1'b0, irq)
    $display("test direct_write done");
    close_out();
  end
endmodule
